// ### rtl/twf_pkg.sv
// package: command codes, widths and reset values for the trigger/wait/fetch core
// What this block does
// - bus trigger command equals group execute trigger
// - trigger layers react only when bus sourced
// - every bus trigger also gives buffer pre-trigger
// - self-test sums program ROM, queues one result
// - self-test result zero passes, one fails
// - queued answers leave only when addressed to talk
// - sequential commands finish before next one starts
// - wait command holds until overlapped work done
// - only initiate and trigger are overlapped
// - initiate pending until device back in idle
// - trigger pending until trigger pointer settles
// - fetch returns reading, configuration left unchanged
// - latest format may repeat the last reading
// - fresh format never repeats, blocks for new
// - fresh format after power-on, command changes it
// - reset and preset commands keep fetch format
// - read does abort, initiate, then fetch
// - measure does abort, configure, then read
// - configure selects one-shot mode for function
// - status bit 4 shows output queue occupied
package twf_pkg;
    localparam int CMD_W = 4;
    localparam int FUNC_W = 4;
    localparam int RDG_W = 32;
    localparam int ROM_AW = 10;
    localparam int ROM_DW = 16;
    localparam int QUEUE_AW = 3;
    localparam int MAV_BIT = 4;
    localparam logic RST_FRESH_FMT = 1'b1;
    localparam logic [RDG_W-1:0] TEST_PASS = 32'h0000_0000;
    localparam logic [RDG_W-1:0] TEST_FAIL = 32'h0000_0001;

    typedef enum logic [CMD_W-1:0] {
        CMD_NOP = 4'h0,
        CMD_TRG = 4'h1,
        CMD_TST = 4'h2,
        CMD_WAI = 4'h3,
        CMD_INIT = 4'h4,
        CMD_ABORT = 4'h5,
        CMD_FETCH = 4'h6,
        CMD_READ = 4'h7,
        CMD_MEAS = 4'h8,
        CMD_CONF = 4'h9,
        CMD_RST = 4'hA,
        CMD_PRESET = 4'hB,
        CMD_FMT_LATEST = 4'hC,
        CMD_FMT_FRESH = 4'hD
    } twf_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_EXEC = 3'b011,
        ST_RD_INIT = 3'b010,
        ST_FETCH = 3'b110,
        ST_CONF = 3'b111,
        ST_TEST = 3'b101,
        ST_WAIT = 3'b100
    } twf_state_t;
endpackage

// ### rtl/twf_chk_if.sv
// interface: start and result of the ROM checksum engine
`timescale 1ns/10ps
`default_nettype none
interface twf_chk_if;
    logic start;
    logic done;
    logic fail;
    modport main (output start, input done, input fail);
    modport chk (input start, output done, output fail);
endinterface
`default_nettype wire

// ### rtl/twf_cmd_fifo.sv
// memory: input command buffer with registered read data
`timescale 1ns/10ps
`default_nettype none
module twf_cmd_fifo #(
    parameter int W = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_en,
    output logic [W-1:0] rd_data,
    output logic empty
);
    localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
        logic [W-1:0] rd_data;
        logic ready;
    } twf_fifo_st_t;

    twf_fifo_st_t s;
    twf_fifo_st_t next_s;
    logic [W-1:0] mem [0:(1<<AW)-1];
    logic push;

    assign push = wr_en && s.ready;
    assign empty = (s.wptr == s.rptr);
    assign wr_ready = s.ready;
    assign rd_data = s.rd_data;

    always_comb
    begin
        next_s = s;
        if (push)
            next_s.wptr = s.wptr + 1'b1;
        if (rd_en && !empty)
        begin
            next_s.rd_data = mem[s.rptr[AW-1:0]];
            next_s.rptr = s.rptr + 1'b1;
        end
        next_s.ready = (next_s.wptr - next_s.rptr) != DEPTH;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s <= '{wptr: '0, rptr: '0, rd_data: '0, ready: 1'b1};
        else
            s <= next_s;
    end

    // storage has no reset: only words below the write pointer are ever read
    always_ff @(posedge clk)
    begin
        if (push)
            mem[s.wptr[AW-1:0]] <= wr_data;
    end

    a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!reset_n)
        !s.ready |=> (s.wptr - s.rptr) == DEPTH || !$stable(s.rptr))
        else $error("command buffer overran");
endmodule
`default_nettype wire

// ### rtl/twf_rom_check.sv
// ROM checksum engine: sums every program ROM word and compares
`timescale 1ns/10ps
`default_nettype none
module twf_rom_check #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    twf_chk_if.chk c,
    output logic [AW-1:0] rom_addr,
    input wire logic [DW-1:0] rom_data,
    input wire logic [DW-1:0] sum_ref
);
    typedef struct packed {
        logic run;
        logic vld;
        logic fin;
        logic [AW-1:0] addr;
        logic [DW-1:0] sum;
        logic done;
        logic fail;
    } twf_chk_st_t;

    twf_chk_st_t s;
    twf_chk_st_t next_s;

    assign rom_addr = s.addr;
    assign c.done = s.done;
    assign c.fail = s.fail;

    // ROM answers one cycle after the address, so issue and sum are pipelined
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.vld = s.run;
        next_s.fin = s.run && (s.addr == '1);
        if (s.run)
        begin
            if (s.addr == '1)
                next_s.run = 1'b0;
            else
                next_s.addr = s.addr + 1'b1;
        end
        if (s.vld)
            next_s.sum = s.sum + rom_data;
        if (s.fin)
        begin
            next_s.done = 1'b1;
            next_s.fail = (next_s.sum != sum_ref);
        end
        if (!s.run && !s.vld && c.start)
        begin
            next_s.run = 1'b1;
            next_s.addr = '0;
            next_s.sum = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    a_chk_done_time: assert property (@(posedge clk) disable iff (!reset_n)
        s.fin |=> s.done && !s.run)
        else $error("checksum done not raised after last word");
endmodule
`default_nettype wire

// ### rtl/twf_core.sv
// top: command execution core for trigger, self-test, wait and fetch commands
`timescale 1ns/10ps
`default_nettype none
module twf_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic [twf_pkg::CMD_W-1:0] cmd_code,
    input wire logic [twf_pkg::FUNC_W-1:0] cmd_func,
    output logic cmd_ready,
    input wire logic get_msg,
    input wire logic talk_addr,
    input wire logic [2:0] trg_src_bus,
    input wire logic model_idle,
    input wire logic model_settled,
    input wire logic rdg_valid,
    input wire logic [twf_pkg::RDG_W-1:0] rdg_data,
    output logic [twf_pkg::ROM_AW-1:0] rom_addr,
    input wire logic [twf_pkg::ROM_DW-1:0] rom_data,
    input wire logic [twf_pkg::ROM_DW-1:0] rom_sum_ref,
    output logic arm_event,
    output logic scan_event,
    output logic meas_event,
    output logic pretrig_event,
    output logic abort_req,
    output logic init_req,
    output logic conf_req,
    output logic [twf_pkg::FUNC_W-1:0] conf_func,
    output logic tx_valid,
    output logic [twf_pkg::RDG_W-1:0] tx_data,
    output logic status_mav,
    output logic fetch_fresh,
    output logic exec_hold
);
    typedef struct packed {
        twf_pkg::twf_state_t st;
        twf_pkg::twf_cmd_t cmd;
        logic [twf_pkg::FUNC_W-1:0] func;
        logic get_pend;
        logic pend_init;
        logic busy_seen;
        logic pend_trg;
        logic [2:0] trg_ev;
        logic pre_ev;
        logic abort;
        logic init;
        logic conf;
        logic [twf_pkg::FUNC_W-1:0] conf_func;
        logic oq_full;
        logic [twf_pkg::RDG_W-1:0] oq_data;
        logic tx_valid;
        logic [twf_pkg::RDG_W-1:0] tx_data;
        logic mav;
        logic fresh_fmt;
        logic [twf_pkg::RDG_W-1:0] rdg_last;
        logic rdg_have;
        logic rdg_new;
        logic force_new;
        logic chk_start;
        logic hold;
    } twf_core_st_t;

    twf_core_st_t s;
    twf_core_st_t next_s;
    twf_chk_if chk ();
    logic pop;
    logic q_empty;
    logic [twf_pkg::CMD_W+twf_pkg::FUNC_W-1:0] q_data;
    logic fetch_ok;

    ////////////////////////////////////////////////////////////////////////////
    // input buffer and checksum engine

    twf_cmd_fifo #(
        .W(twf_pkg::CMD_W + twf_pkg::FUNC_W),
        .AW(twf_pkg::QUEUE_AW)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(cmd_valid),
        .wr_data({cmd_func, cmd_code}),
        .wr_ready(cmd_ready),
        .rd_en(pop),
        .rd_data(q_data),
        .empty(q_empty)
    );

    twf_rom_check #(
        .AW(twf_pkg::ROM_AW),
        .DW(twf_pkg::ROM_DW)
    ) u_chk (
        .clk(clk),
        .reset_n(reset_n),
        .c(chk.chk),
        .rom_addr(rom_addr),
        .rom_data(rom_data),
        .sum_ref(rom_sum_ref)
    );

    ////////////////////////////////////////////////////////////////////////////
    // execution state machine

    // a bus message trigger is served ahead of queued commands
    assign pop = (s.st == twf_pkg::ST_IDLE) && !s.get_pend && !q_empty;
    assign fetch_ok = (s.fresh_fmt || s.force_new) ? s.rdg_new : s.rdg_have;
    assign chk.start = s.chk_start;

    always_comb
    begin
        next_s = s;
        next_s.trg_ev = 3'b000;
        next_s.pre_ev = 1'b0;
        next_s.abort = 1'b0;
        next_s.init = 1'b0;
        next_s.conf = 1'b0;
        next_s.tx_valid = 1'b0;
        next_s.chk_start = 1'b0;
        next_s.get_pend = s.get_pend || get_msg;

        // overlapped work tracking
        if (s.pend_init && !model_idle)
            next_s.busy_seen = 1'b1;
        if (s.pend_init && s.busy_seen && model_idle)
        begin
            next_s.pend_init = 1'b0;
            next_s.busy_seen = 1'b0;
        end
        if (model_settled)
            next_s.pend_trg = 1'b0;

        // newest reading; a capture beats a fetch that clears the flag
        if (rdg_valid)
        begin
            next_s.rdg_last = rdg_data;
            next_s.rdg_have = 1'b1;
        end

        // output queue drains only toward a talking controller
        if (talk_addr && s.oq_full)
        begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = s.oq_data;
            next_s.oq_full = 1'b0;
        end

        case (s.st)
            twf_pkg::ST_IDLE:
            begin
                if (s.get_pend)
                begin
                    next_s.get_pend = get_msg;
                    next_s.trg_ev = trg_src_bus;
                    next_s.pre_ev = 1'b1;
                    if (|trg_src_bus)
                        next_s.pend_trg = 1'b1;
                end
                else if (!q_empty)
                    next_s.st = twf_pkg::ST_LOAD;
            end
            twf_pkg::ST_LOAD:
            begin
                next_s.cmd = twf_pkg::twf_cmd_t'(q_data[twf_pkg::CMD_W-1:0]);
                next_s.func = q_data[twf_pkg::CMD_W+twf_pkg::FUNC_W-1:twf_pkg::CMD_W];
                next_s.st = twf_pkg::ST_EXEC;
            end
            twf_pkg::ST_EXEC:
            begin
                next_s.st = twf_pkg::ST_IDLE;
                case (s.cmd)
                    twf_pkg::CMD_TRG:
                    begin
                        next_s.trg_ev = trg_src_bus;
                        next_s.pre_ev = 1'b1;
                        if (|trg_src_bus)
                            next_s.pend_trg = 1'b1;
                    end
                    twf_pkg::CMD_INIT:
                    begin
                        next_s.init = 1'b1;
                        next_s.pend_init = 1'b1;
                        next_s.busy_seen = 1'b0;
                    end
                    twf_pkg::CMD_WAI: next_s.st = twf_pkg::ST_WAIT;
                    twf_pkg::CMD_TST:
                    begin
                        next_s.chk_start = !s.oq_full;
                        next_s.st = s.oq_full ? twf_pkg::ST_EXEC : twf_pkg::ST_TEST;
                    end
                    twf_pkg::CMD_ABORT: next_s.abort = 1'b1;
                    twf_pkg::CMD_FETCH: next_s.st = twf_pkg::ST_FETCH;
                    twf_pkg::CMD_READ:
                    begin
                        next_s.abort = 1'b1;
                        next_s.st = twf_pkg::ST_RD_INIT;
                    end
                    twf_pkg::CMD_MEAS:
                    begin
                        next_s.abort = 1'b1;
                        next_s.st = twf_pkg::ST_CONF;
                    end
                    twf_pkg::CMD_CONF:
                    begin
                        next_s.conf = 1'b1;
                        next_s.conf_func = s.func;
                    end
                    twf_pkg::CMD_FMT_LATEST: next_s.fresh_fmt = 1'b0;
                    twf_pkg::CMD_FMT_FRESH: next_s.fresh_fmt = 1'b1;
                    // reset and preset settings live elsewhere; format stays
                    twf_pkg::CMD_RST, twf_pkg::CMD_PRESET: next_s.fresh_fmt = s.fresh_fmt;
                    default: next_s.st = twf_pkg::ST_IDLE;
                endcase
            end
            twf_pkg::ST_CONF:
            begin
                next_s.conf = 1'b1;
                next_s.conf_func = s.func;
                next_s.abort = 1'b1;
                next_s.st = twf_pkg::ST_RD_INIT;
            end
            twf_pkg::ST_RD_INIT:
            begin
                // the fetch must wait for a reading of this initiate
                next_s.init = 1'b1;
                next_s.pend_init = 1'b1;
                next_s.busy_seen = 1'b0;
                next_s.force_new = 1'b1;
                next_s.rdg_new = 1'b0;
                next_s.st = twf_pkg::ST_FETCH;
            end
            twf_pkg::ST_FETCH:
            begin
                if (fetch_ok && !s.oq_full)
                begin
                    next_s.oq_full = 1'b1;
                    next_s.oq_data = s.rdg_last;
                    next_s.rdg_new = 1'b0;
                    next_s.force_new = 1'b0;
                    next_s.st = twf_pkg::ST_IDLE;
                end
            end
            twf_pkg::ST_TEST:
            begin
                if (chk.done)
                begin
                    next_s.oq_full = 1'b1;
                    next_s.oq_data = chk.fail ? twf_pkg::TEST_FAIL : twf_pkg::TEST_PASS;
                    next_s.st = twf_pkg::ST_IDLE;
                end
            end
            twf_pkg::ST_WAIT:
            begin
                if (!s.pend_init && !s.pend_trg)
                    next_s.st = twf_pkg::ST_IDLE;
            end
            default: next_s.st = twf_pkg::ST_IDLE;
        endcase

        if (rdg_valid && s.st != twf_pkg::ST_RD_INIT)
            next_s.rdg_new = 1'b1;
        next_s.mav = next_s.oq_full;
        next_s.hold = (next_s.st == twf_pkg::ST_WAIT) || (next_s.st == twf_pkg::ST_FETCH);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s <= '0;
            s.fresh_fmt <= twf_pkg::RST_FRESH_FMT;
        end
        else
            s <= next_s;
    end

    assign arm_event = s.trg_ev[0];
    assign scan_event = s.trg_ev[1];
    assign meas_event = s.trg_ev[2];
    assign pretrig_event = s.pre_ev;
    assign abort_req = s.abort;
    assign init_req = s.init;
    assign conf_req = s.conf;
    assign conf_func = s.conf_func;
    assign tx_valid = s.tx_valid;
    assign tx_data = s.tx_data;
    assign status_mav = s.mav;
    assign fetch_fresh = s.fresh_fmt;
    assign exec_hold = s.hold;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_trg_src_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (s.trg_ev & ~$past(trg_src_bus)) == 3'b000)
        else $error("trigger event without bus control source");

    a_pretrig_with: assert property (@(posedge clk) disable iff (!reset_n)
        (|s.trg_ev) |-> s.pre_ev)
        else $error("trigger event without pre-trigger");

    a_test_code: assert property (@(posedge clk) disable iff (!reset_n)
        (s.st == twf_pkg::ST_TEST && chk.done) |=> s.oq_full
        && s.oq_data == (chk.fail ? 32'h0000_0001 : 32'h0000_0000))
        else $error("self-test result code wrong");

    a_queue_holds: assert property (@(posedge clk) disable iff (!reset_n)
        (s.oq_full && !talk_addr) |=> s.oq_full && $stable(s.oq_data) && !s.tx_valid)
        else $error("response left queue without talk address");

    a_mav_bit: assert property (@(posedge clk) disable iff (!reset_n)
        (s.mav == s.oq_full) and (s.tx_valid |-> $past(s.mav)))
        else $error("message available inconsistent with transmit");

    a_wait_holds: assert property (@(posedge clk) disable iff (!reset_n)
        (s.st == twf_pkg::ST_WAIT && s.pend_init) |=> s.st == twf_pkg::ST_WAIT)
        else $error("wait released while initiate pending");

    a_fresh_block: assert property (@(posedge clk) disable iff (!reset_n)
        (s.st == twf_pkg::ST_FETCH && s.fresh_fmt && !s.rdg_new) |=> !$rose(s.oq_full))
        else $error("fresh fetch returned an old reading");

    a_fmt_power_on: assert property (@(posedge clk)
        !reset_n |=> s.fresh_fmt)
        else $error("fetch format not fresh after reset");

    a_fmt_keep: assert property (@(posedge clk) disable iff (!reset_n)
        (s.st == twf_pkg::ST_EXEC && (s.cmd == twf_pkg::CMD_RST
        || s.cmd == twf_pkg::CMD_PRESET)) |=> $stable(s.fresh_fmt))
        else $error("reset command changed fetch format");

    a_read_order: assert property (@(posedge clk) disable iff (!reset_n)
        (s.st == twf_pkg::ST_EXEC && s.cmd == twf_pkg::CMD_READ)
        |=> s.abort ##1 s.init ##1 s.st == twf_pkg::ST_FETCH)
        else $error("read sequence out of order");

    a_meas_order: assert property (@(posedge clk) disable iff (!reset_n)
        (s.st == twf_pkg::ST_EXEC && s.cmd == twf_pkg::CMD_MEAS)
        |=> s.abort ##1 s.conf ##1 s.init)
        else $error("measure sequence out of order");
endmodule
`default_nettype wire

// ### verif/twf_far_model.sv
// far-side model: program ROM answering the checksum engine one cycle late
`timescale 1ns/10ps
`default_nettype none
module twf_far_model (
    input wire logic clk,
    input wire logic [twf_pkg::ROM_AW-1:0] rom_addr,
    output logic [twf_pkg::ROM_DW-1:0] rom_data
);
    ////////////////////////////////////////////////////////////////////////////
    // each word holds its own address, so the bench can work out the sum
    always @(posedge clk)
    begin
        rom_data <= 16'(rom_addr);
    end
endmodule
`default_nettype wire

// ### verif/tb_twf_core.sv
// testbench: self-checking scenarios for the trigger, self-test, wait and fetch core
`timescale 1ns/10ps
`default_nettype none
module tb_twf_core;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic [3:0] cmd_func = 4'h0;
    logic get_msg = 1'b0;
    logic talk_addr = 1'b0;
    logic [2:0] trg_src_bus = 3'b000;
    logic model_idle = 1'b1;
    logic model_settled = 1'b1;
    logic rdg_valid = 1'b0;
    logic [31:0] rdg_data = 32'h0000_0000;
    logic [15:0] rom_sum_ref = 16'hfe00;
    logic [9:0] rom_addr;
    logic [15:0] rom_data;
    logic cmd_ready, arm_event, scan_event, meas_event, pretrig_event;
    logic abort_req, init_req, conf_req, tx_valid, status_mav, fetch_fresh, exec_hold;
    logic [3:0] conf_func;
    logic [31:0] tx_data;
    int errors = 0;
    int comparisons = 0;
    int cnt[7];
    int t_ev[7];
    int cyc = 0;
    logic [6:0] ev_vec;

    ////////////////////////////////////////////////////////////////////////////
    twf_core dut_u (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_func(cmd_func), .cmd_ready(cmd_ready),
        .get_msg(get_msg), .talk_addr(talk_addr), .trg_src_bus(trg_src_bus),
        .model_idle(model_idle), .model_settled(model_settled), .rdg_valid(rdg_valid),
        .rdg_data(rdg_data), .rom_addr(rom_addr), .rom_data(rom_data),
        .rom_sum_ref(rom_sum_ref), .arm_event(arm_event), .scan_event(scan_event),
        .meas_event(meas_event), .pretrig_event(pretrig_event), .abort_req(abort_req),
        .init_req(init_req), .conf_req(conf_req), .conf_func(conf_func),
        .tx_valid(tx_valid), .tx_data(tx_data), .status_mav(status_mav),
        .fetch_fresh(fetch_fresh), .exec_hold(exec_hold));
    twf_far_model far_u (.clk(clk), .rom_addr(rom_addr), .rom_data(rom_data));
    assign ev_vec = {conf_req, init_req, abort_req, pretrig_event, meas_event, scan_event,
        arm_event};

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // pulse counters and the cycle of the latest pulse, for order checks
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        foreach (cnt[k])
        begin
            if (ev_vec[k] === 1'b1)
            begin
                cnt[k] <= cnt[k] + 1;
                t_ev[k] <= cyc;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic clear_counts();
        foreach (cnt[k]) cnt[k] = 0;
    endtask

    task automatic send(input twf_pkg::twf_cmd_t code, input logic [3:0] func);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_func = func;
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask

    task automatic reading(input logic [31:0] value);
        @(negedge clk);
        rdg_valid = 1'b1;
        rdg_data = value;
        @(negedge clk);
        rdg_valid = 1'b0;
    endtask

    // answers leave only once the controller addresses the core to talk
    task automatic rd_answer(input logic [31:0] exp);
        int i;
        i = 0;
        while (status_mav !== 1'b1 && i < 3000)
        begin
            @(negedge clk);
            i++;
        end
        check(32'(status_mav), 32'h1, "message available");
        idle(3);
        check(32'(tx_valid), 32'h0, "answer sent unasked");
        talk_addr = 1'b1;
        i = 0;
        while (tx_valid !== 1'b1 && i < 10)
        begin
            @(negedge clk);
            i++;
        end
        talk_addr = 1'b0;
        check(tx_data, exp, "answer word");
        check(32'(status_mav), 32'h0, "queue empty after talk");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_self_test();
        send(twf_pkg::CMD_TST, 4'h0);
        rd_answer(twf_pkg::TEST_PASS);
        rom_sum_ref = 16'hfe01;
        send(twf_pkg::CMD_TST, 4'h0);
        rd_answer(twf_pkg::TEST_FAIL);
        rom_sum_ref = 16'hfe00;
    endtask

    task automatic t_trigger();
        trg_src_bus = 3'b101;
        clear_counts();
        send(twf_pkg::CMD_TRG, 4'h0);
        idle(10);
        check(cnt[0] + cnt[1] * 2 + cnt[2] * 4, 5, "bus trigger layers");
        check(cnt[3], 1, "bus trigger pre-trigger");
        trg_src_bus = 3'b010;
        clear_counts();
        get_msg = 1'b1;
        @(negedge clk);
        get_msg = 1'b0;
        idle(10);
        check(cnt[0] + cnt[1] * 2 + cnt[2] * 4, 2, "group trigger layers");
        check(cnt[3], 1, "group trigger pre-trigger");
    endtask

    task automatic t_wait();
        clear_counts();
        send(twf_pkg::CMD_INIT, 4'h0);
        send(twf_pkg::CMD_WAI, 4'h0);
        send(twf_pkg::CMD_TRG, 4'h0);
        idle(30);
        check(cnt[5], 1, "initiate ran");
        check(cnt[3], 0, "trigger held by wait");
        check(32'(exec_hold), 32'h1, "hold shown");
        model_idle = 1'b0;
        idle(3);
        check(cnt[3], 0, "held while not idle");
        model_idle = 1'b1;
        idle(10);
        check(cnt[3], 1, "trigger after idle");
        check(32'(exec_hold), 32'h0, "hold released");
        model_settled = 1'b0;
        clear_counts();
        send(twf_pkg::CMD_TRG, 4'h0);
        send(twf_pkg::CMD_WAI, 4'h0);
        send(twf_pkg::CMD_ABORT, 4'h0);
        idle(20);
        check(cnt[4], 0, "abort held by trigger");
        model_settled = 1'b1;
        idle(10);
        check(cnt[4], 1, "abort after settle");
    endtask

    task automatic t_fetch();
        check(32'(fetch_fresh), 32'h1, "format after reset");
        reading(32'h0000_00a5);
        send(twf_pkg::CMD_FETCH, 4'h0);
        rd_answer(32'h0000_00a5);
        send(twf_pkg::CMD_FETCH, 4'h0);
        idle(20);
        check(32'(status_mav), 32'h0, "fresh fetch blocks");
        check(32'(exec_hold), 32'h1, "fresh fetch holds");
        reading(32'h0000_5a5a);
        rd_answer(32'h0000_5a5a);
        send(twf_pkg::CMD_FMT_LATEST, 4'h0);
        send(twf_pkg::CMD_RST, 4'h0);
        send(twf_pkg::CMD_PRESET, 4'h0);
        idle(10);
        check(32'(fetch_fresh), 32'h0, "format kept over reset");
        repeat (2)
        begin
            send(twf_pkg::CMD_FETCH, 4'h0);
            rd_answer(32'h0000_5a5a);
        end
        send(twf_pkg::CMD_FMT_FRESH, 4'h0);
        idle(10);
        check(32'(fetch_fresh), 32'h1, "fresh format again");
    endtask

    task automatic t_read_measure();
        clear_counts();
        send(twf_pkg::CMD_READ, 4'h0);
        idle(10);
        check(cnt[4] * 16 + cnt[5], 32'h11, "read steps");
        check(32'(t_ev[4] < t_ev[5]), 32'h1, "abort before initiate");
        reading(32'h0001_0000);
        rd_answer(32'h0001_0000);
        clear_counts();
        send(twf_pkg::CMD_MEAS, 4'h3);
        idle(10);
        check(32'(conf_func), 32'h3, "configured function");
        check(cnt[6] * 16 + cnt[5], 32'h11, "measure steps");
        check(32'(t_ev[6] < t_ev[5]), 32'h1, "configure before initiate");
        reading(32'h0002_0000);
        rd_answer(32'h0002_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        check(32'(cmd_ready), 32'h1, "ready after reset");
        check(32'(status_mav), 32'h0, "queue empty at reset");
        t_fetch();
        t_self_test();
        t_trigger();
        t_wait();
        t_read_measure();
        tally_and_finish();
    end

    // the whole run takes about 2300 cycles
    initial
    begin
        #400000;
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
